// File: rtl/slmp_pkg.sv
// Package with constants shared by the strap latch and modem pin block.
`default_nettype none
package slmp_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses on the Avalon-MM slave)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STRAP = 4'h8;

  // ----------------------------------------------------------------
  // Port and field layout
  // ----------------------------------------------------------------
  localparam int NPORT = 3;
  localparam int CTRL_BITS = 3;   // Per port: dtr, rts, tx level.
  localparam int CTRL_DTR = 0;
  localparam int CTRL_RTS = 1;
  localparam int CTRL_TX = 2;
  localparam int STAT_BITS = 5;   // Per port: dcd, ri, cts, dsr, rx.
  localparam int STAT_DCD = 0;
  localparam int STAT_RI = 1;
  localparam int STAT_CTS = 2;
  localparam int STAT_DSR = 3;
  localparam int STAT_RX = 4;
  localparam int NSHARE = 6;      // Output pins of ports 1 and 2.
  localparam int PIN_FAN_DUTY = 0;   // Terminal ready, port 1.
  localparam int PIN_I2C_ADDR = 1;   // Request to send, port 1.
  localparam int PIN_CFG_PORT = 2;   // Serial output, port 1.
  localparam int PIN_FW_HUB = 3;     // Terminal ready, port 2.
  localparam int PIN_FAN_MODE = 4;   // Request to send, port 2.
  localparam int STRAP_DUTY_LSB = 0;
  localparam int STRAP_ADDR_LSB = 8;
  localparam int STRAP_CFG_LSB = 16;
  localparam int STRAP_PWM = 24;
  localparam int STRAP_HUB_EN = 25;
  localparam int STRAP_DONE = 26;
  localparam logic [8:0] CTRL_RESET = 9'h124;  // Tx idles high.

  // ----------------------------------------------------------------
  // Strap decode values
  // ----------------------------------------------------------------
  localparam logic [7:0] DUTY_STRAP_HI = 8'h3C;  // 60 percent.
  localparam logic [7:0] DUTY_STRAP_LO = 8'h64;  // 100 percent.
  localparam logic [7:0] I2C_STRAP_HI = 8'h5C;
  localparam logic [7:0] I2C_STRAP_LO = 8'h5A;
  localparam logic [7:0] CFG_STRAP_HI = 8'h4E;   // Data port is +1.
  localparam logic [7:0] CFG_STRAP_LO = 8'h2E;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int SETTLE_NS = 100;  // Least time pins float before sample.
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;

  typedef enum logic {SLMP_SETTLE, SLMP_RUN} slmp_state_t;
endpackage
`default_nettype wire

// File: rtl/slmp_top.sv
// Strap latch and modem control pins for serial ports one to three.
// ------------------------------------------------------------------
// What this block does
// - Fan duty strap: high 60, low 100.
// - Address strap: high 5C, low 5A.
// - Fan mode strap: high pulse width, low linear.
// - Floating strap reads one, the default.
// - Terminal ready driven low when ready.
// - Request to send driven low when ready.
// - Serial out drives tx, serial in gives rx.
// ------------------------------------------------------------------
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module slmp_top
  import slmp_pkg::*;
#(
  parameter int SETTLE = slmp_pkg::SETTLE_CYC
) (
  input wire logic clk,                              // System clock.
  input wire logic reset,                            // Async, high.
  input wire logic [slmp_pkg::ADDR_W-1:0] address,   // Byte address.
  input wire logic read,                             // Read request.
  input wire logic write,                            // Write request.
  input wire logic [31:0] writedata,                 // Write data.
  output logic [31:0] readdata,                      // Read data.
  output logic waitrequest,                          // Stall, high.
  input wire logic terminal_ready_n_port1_i,         // Pin level in.
  output logic terminal_ready_n_port1_o,             // Pin level out.
  output logic terminal_ready_n_port1_oe,            // Pin drive.
  input wire logic request_send_n_port1_i,           // Pin level in.
  output logic request_send_n_port1_o,               // Pin level out.
  output logic request_send_n_port1_oe,              // Pin drive.
  input wire logic serial_tx_port1_i,                // Pin level in.
  output logic serial_tx_port1_o,                    // Pin level out.
  output logic serial_tx_port1_oe,                   // Pin drive.
  input wire logic terminal_ready_n_port2_i,         // Pin level in.
  output logic terminal_ready_n_port2_o,             // Pin level out.
  output logic terminal_ready_n_port2_oe,            // Pin drive.
  input wire logic request_send_n_port2_i,           // Pin level in.
  output logic request_send_n_port2_o,               // Pin level out.
  output logic request_send_n_port2_oe,              // Pin drive.
  input wire logic serial_tx_port2_i,                // Pin level in.
  output logic serial_tx_port2_o,                    // Pin level out.
  output logic serial_tx_port2_oe,                   // Pin drive.
  output logic terminal_ready_n_port3,               // Port 3 out.
  output logic request_send_n_port3,                 // Port 3 out.
  output logic serial_tx_port3,                      // Port 3 out.
  input wire logic carrier_detect_n_port1,           // Modem input.
  input wire logic ring_indicate_n_port1,            // Modem input.
  input wire logic clear_to_send_n_port1,            // Modem input.
  input wire logic set_ready_n_port1,                // Modem input.
  input wire logic serial_rx_port1,                  // Serial input.
  input wire logic carrier_detect_n_port2,           // Modem input.
  input wire logic ring_indicate_n_port2,            // Modem input.
  input wire logic clear_to_send_n_port2,            // Modem input.
  input wire logic set_ready_n_port2,                // Modem input.
  input wire logic serial_rx_port2,                  // Serial input.
  input wire logic carrier_detect_n_port3,           // Modem input.
  input wire logic ring_indicate_n_port3,            // Modem input.
  input wire logic clear_to_send_n_port3,            // Modem input.
  input wire logic set_ready_n_port3,                // Modem input.
  input wire logic serial_rx_port3,                  // Serial input.
  output logic [7:0] fan_duty_pct,                   // Default duty.
  output logic fan_pwm_mode,                         // 1 pwm, 0 dac.
  output logic [7:0] i2c_slave_addr,                 // Slave address.
  output logic [7:0] config_index_port,              // Index port.
  output logic firmware_hub_enable,                  // Strap copy.
  output logic strap_done                            // Straps latched; pins driven a cycle later.
);
  import slmp_pkg::*;

  localparam int NMDM = NPORT * STAT_BITS;

  slmp_state_t state_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [NSHARE-1:0] strap_meta_ff, strap_sync_ff;
  logic [NMDM-1:0] mdm_meta_ff, mdm_sync_ff;
  logic [NPORT*CTRL_BITS-1:0] ctrl_ff, pin_out_ff;
  logic pin_oe_ff;
  logic [NMDM-1:0] mdm_raw, mdm_active;
  logic [NPORT*CTRL_BITS-1:0] nxt_pin_out;
  logic [31:0] nxt_readdata, strap_word;
  logic req, take;

  // Cycle a request is answered: waitrequest drops for one cycle.
  assign req = read | write;
  assign take = req & ~waitrequest;

  // Raw modem inputs gathered per port as dcd, ri, cts, dsr, rx.
  assign mdm_raw = {serial_rx_port3, set_ready_n_port3,
                    clear_to_send_n_port3, ring_indicate_n_port3,
                    carrier_detect_n_port3,
                    serial_rx_port2, set_ready_n_port2,
                    clear_to_send_n_port2, ring_indicate_n_port2,
                    carrier_detect_n_port2,
                    serial_rx_port1, set_ready_n_port1,
                    clear_to_send_n_port1, ring_indicate_n_port1,
                    carrier_detect_n_port1};

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // Every pin crosses two flops before any logic looks at it.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_meta_ff <= '1;
      strap_sync_ff <= '1;
      mdm_meta_ff <= '1;
      mdm_sync_ff <= '1;
    end else begin
      strap_meta_ff <= {serial_tx_port2_i, request_send_n_port2_i,
                        terminal_ready_n_port2_i, serial_tx_port1_i,
                        request_send_n_port1_i, terminal_ready_n_port1_i};
      strap_sync_ff <= strap_meta_ff;
      mdm_meta_ff <= mdm_raw;
      mdm_sync_ff <= mdm_meta_ff;
    end
  end

  // Active-low modem lines shown active high; rx stays as the line.
  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_mdm
      assign mdm_active[gp*STAT_BITS+STAT_DCD] =
        ~mdm_sync_ff[gp*STAT_BITS+STAT_DCD];
      assign mdm_active[gp*STAT_BITS+STAT_RI] =
        ~mdm_sync_ff[gp*STAT_BITS+STAT_RI];
      assign mdm_active[gp*STAT_BITS+STAT_CTS] =
        ~mdm_sync_ff[gp*STAT_BITS+STAT_CTS];
      assign mdm_active[gp*STAT_BITS+STAT_DSR] =
        ~mdm_sync_ff[gp*STAT_BITS+STAT_DSR];
      assign mdm_active[gp*STAT_BITS+STAT_RX] =
        mdm_sync_ff[gp*STAT_BITS+STAT_RX];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Strap sequencer
  // ----------------------------------------------------------------
  // Pins float after release; the pad pull-up must settle first.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= SLMP_SETTLE;
      cnt_ff <= '0;
    end else begin
      unique case (state_ff)
        SLMP_SETTLE: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == CNT_W'(SETTLE - 1)) begin
            state_ff <= SLMP_RUN;
          end
        end
        SLMP_RUN: begin
          state_ff <= SLMP_RUN;
        end
      endcase
    end
  end

  // Latched straps; reset holds the defaults of a floating pin.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fan_duty_pct <= DUTY_STRAP_HI;
      i2c_slave_addr <= I2C_STRAP_HI;
      config_index_port <= CFG_STRAP_HI;
      fan_pwm_mode <= 1'b1;
      firmware_hub_enable <= 1'b1;
      strap_done <= 1'b0;
    end else if (state_ff == SLMP_SETTLE &&
                 cnt_ff == CNT_W'(SETTLE - 1)) begin
      // Taken once only; later pin activity never reaches here.
      fan_duty_pct <= strap_sync_ff[PIN_FAN_DUTY] ?
                      DUTY_STRAP_HI : DUTY_STRAP_LO;
      i2c_slave_addr <= strap_sync_ff[PIN_I2C_ADDR] ?
                        I2C_STRAP_HI : I2C_STRAP_LO;
      config_index_port <= strap_sync_ff[PIN_CFG_PORT] ?
                           CFG_STRAP_HI : CFG_STRAP_LO;
      fan_pwm_mode <= strap_sync_ff[PIN_FAN_MODE];
      firmware_hub_enable <= strap_sync_ff[PIN_FW_HUB];
      strap_done <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Asserting a handshake in control pulls its pin low.
  always_comb begin
    nxt_pin_out = ctrl_ff;
    for (int i = 0; i < NPORT; i++) begin
      nxt_pin_out[i*CTRL_BITS+CTRL_DTR] =
        ~ctrl_ff[i*CTRL_BITS+CTRL_DTR];
      nxt_pin_out[i*CTRL_BITS+CTRL_RTS] =
        ~ctrl_ff[i*CTRL_BITS+CTRL_RTS];
    end
  end

  // Shared pins stay undriven until the straps are latched.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_out_ff <= '1;
      pin_oe_ff <= 1'b0;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= strap_done;
    end
  end

  assign terminal_ready_n_port1_o = pin_out_ff[CTRL_DTR];
  assign request_send_n_port1_o = pin_out_ff[CTRL_RTS];
  assign serial_tx_port1_o = pin_out_ff[CTRL_TX];
  assign terminal_ready_n_port2_o = pin_out_ff[CTRL_BITS+CTRL_DTR];
  assign request_send_n_port2_o = pin_out_ff[CTRL_BITS+CTRL_RTS];
  assign serial_tx_port2_o = pin_out_ff[CTRL_BITS+CTRL_TX];
  assign terminal_ready_n_port3 = pin_out_ff[2*CTRL_BITS+CTRL_DTR];
  assign request_send_n_port3 = pin_out_ff[2*CTRL_BITS+CTRL_RTS];
  assign serial_tx_port3 = pin_out_ff[2*CTRL_BITS+CTRL_TX];
  assign terminal_ready_n_port1_oe = pin_oe_ff;
  assign request_send_n_port1_oe = pin_oe_ff;
  assign serial_tx_port1_oe = pin_oe_ff;
  assign terminal_ready_n_port2_oe = pin_oe_ff;
  assign request_send_n_port2_oe = pin_oe_ff;
  assign serial_tx_port2_oe = pin_oe_ff;

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // One wait state on every access keeps read data registered.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~(req & waitrequest);
    end
  end

  // Control register; writes land on the edge that sees waitrequest low.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_ff <= CTRL_RESET;
    end else if (take && write && address == OFS_CTRL) begin
      ctrl_ff <= writedata[NPORT*CTRL_BITS-1:0];
    end
  end

  always_comb begin
    strap_word = '0;
    strap_word[STRAP_DUTY_LSB +: 8] = fan_duty_pct;
    strap_word[STRAP_ADDR_LSB +: 8] = i2c_slave_addr;
    strap_word[STRAP_CFG_LSB +: 8] = config_index_port;
    strap_word[STRAP_PWM] = fan_pwm_mode;
    strap_word[STRAP_HUB_EN] = firmware_hub_enable;
    strap_word[STRAP_DONE] = strap_done;
  end

  // Unmapped offsets read as zero.
  always_comb begin
    nxt_readdata = '0;
    unique case (address)
      OFS_CTRL: nxt_readdata[NPORT*CTRL_BITS-1:0] = ctrl_ff;
      OFS_STATUS: nxt_readdata[NMDM-1:0] = mdm_active;
      OFS_STRAP: nxt_readdata = strap_word;
      default: nxt_readdata = '0;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readdata <= '0;
    end else if (read && waitrequest) begin
      readdata <= nxt_readdata;
    end
  end
endmodule
`default_nettype wire

// File: dv/slmp_chk.sv
// Checker for strap decode, pin hand-over and modem output timing.
`timescale 1ns/1ps
`default_nettype none
module slmp_chk
  import slmp_pkg::*;
(
  input wire logic clk, // Clock.
  input wire logic reset, // Async reset.
  input wire logic [slmp_pkg::ADDR_W-1:0] address, // Address.
  input wire logic write, // Write.
  input wire logic [31:0] writedata, // Data.
  input wire logic waitrequest, // Stall.
  input wire logic terminal_ready_n_port1_i, // Strap pin.
  input wire logic request_send_n_port1_i, // Strap pin.
  input wire logic serial_tx_port1_i, // Strap pin.
  input wire logic request_send_n_port2_i, // Strap pin.
  input wire logic terminal_ready_n_port1_oe, // Drive.
  input wire logic terminal_ready_n_port3, // Pin.
  input wire logic request_send_n_port3, // Pin.
  input wire logic serial_tx_port3, // Pin.
  input wire logic [7:0] fan_duty_pct, // Duty.
  input wire logic fan_pwm_mode, // Mode.
  input wire logic [7:0] i2c_slave_addr, // Address.
  input wire logic [7:0] config_index_port, // Index port.
  input wire logic strap_done // Latched.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic wr_ctrl;
  // A control write lands at the edge that sees waitrequest low.
  assign wr_ctrl = write && !waitrequest && address == OFS_CTRL;
  duty_map_a: assert property (
    $rose(strap_done) |-> fan_duty_pct ==
      ($past(terminal_ready_n_port1_i) ? 8'h3C : 8'h64))
    else $error("fan duty strap decoded wrongly");
  addr_map_a: assert property (
    $rose(strap_done) |-> i2c_slave_addr ==
      ($past(request_send_n_port1_i) ? 8'h5C : 8'h5A))
    else $error("slave address strap decoded wrongly");
  mode_map_a: assert property (
    $rose(strap_done) |-> fan_pwm_mode == $past(request_send_n_port2_i))
    else $error("fan mode strap decoded wrongly");
  cfg_map_a: assert property (
    $rose(strap_done) |-> config_index_port ==
      ($past(serial_tx_port1_i) ? 8'h4E : 8'h2E))
    else $error("config port strap decoded wrongly");
  strap_hold_a: assert property (
    strap_done && $past(strap_done) |-> $stable({fan_duty_pct,
      i2c_slave_addr, config_index_port, fan_pwm_mode}))
    else $error("latched strap changed");
  oe_late_a: assert property (
    $rose(strap_done) |-> !terminal_ready_n_port1_oe ##1
      terminal_ready_n_port1_oe)
    else $error("pin drive not one cycle after latch");
  tx_out_a: assert property (
    wr_ctrl |-> ##2 serial_tx_port3 == $past(writedata[8], 2))
    else $error("serial output level wrong");
  dtr_out_a: assert property (
    wr_ctrl |-> ##2 terminal_ready_n_port3 == !$past(writedata[6], 2))
    else $error("terminal ready level wrong");
  rts_out_a: assert property (
    wr_ctrl |-> ##2 request_send_n_port3 == !$past(writedata[7], 2))
    else $error("request to send level wrong");
endmodule
bind slmp_top slmp_chk i_chk (.clk, .reset, .address, .write, .writedata,
  .waitrequest, .terminal_ready_n_port1_i, .request_send_n_port1_i,
  .serial_tx_port1_i, .request_send_n_port2_i, .terminal_ready_n_port1_oe,
  .terminal_ready_n_port3, .request_send_n_port3, .serial_tx_port3,
  .fan_duty_pct, .fan_pwm_mode, .i2c_slave_addr, .config_index_port,
  .strap_done);
`default_nettype wire

// File: dv/slmp_modem.sv
// Modem model driving the control lines of three serial ports.
`timescale 1ns/1ps
`default_nettype none
module slmp_modem (
  input wire logic [14:0] line_state, // Per port: dcd ri cts dsr rx.
  output logic [2:0] dcd_n, // Carrier detect.
  output logic [2:0] ri_n, // Ring indicate.
  output logic [2:0] cts_n, // Clear to send.
  output logic [2:0] dsr_n, // Set ready.
  output logic [2:0] rx // Serial data.
);
  // Active conditions pull dcd, ri, cts and dsr low, idle leaves them high; rx copies its line_state bit.
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      dcd_n[p] = !line_state[5*p];
      ri_n[p] = !line_state[5*p+1];
      cts_n[p] = !line_state[5*p+2];
      dsr_n[p] = !line_state[5*p+3];
      rx[p] = line_state[5*p+4];
    end
  end
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the strap latch and modem pin block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import slmp_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, q;
  logic waitrequest, pwm, hub_en, done;
  logic [5:0] pull_lo = 6'h00;
  logic [5:0] po, poe, pin;
  logic [2:0] p3, dcd_n, ri_n, cts_n, dsr_n, rx;
  logic [14:0] line_state = 15'h0;
  logic [7:0] duty, i2c, cfg;
  int fail_count = 0;
  int n_tests = 0;
  logic [8:0] vals [3] = '{9'h000, 9'h1FF, 9'h0A5};
  always #2 clk = ~clk;
  // Undriven shared pins float to the pad pull-up unless pulled down.
  assign pin = (po & poe) | (~poe & ~pull_lo);
  slmp_top #(.SETTLE(4)) i_dut (.clk, .reset, .address, .read, .write,
    .writedata, .readdata, .waitrequest,
    .terminal_ready_n_port1_i(pin[0]), .terminal_ready_n_port1_o(po[0]),
    .terminal_ready_n_port1_oe(poe[0]), .request_send_n_port1_i(pin[1]),
    .request_send_n_port1_o(po[1]), .request_send_n_port1_oe(poe[1]),
    .serial_tx_port1_i(pin[2]), .serial_tx_port1_o(po[2]),
    .serial_tx_port1_oe(poe[2]), .terminal_ready_n_port2_i(pin[3]),
    .terminal_ready_n_port2_o(po[3]), .terminal_ready_n_port2_oe(poe[3]),
    .request_send_n_port2_i(pin[4]), .request_send_n_port2_o(po[4]),
    .request_send_n_port2_oe(poe[4]), .serial_tx_port2_i(pin[5]),
    .serial_tx_port2_o(po[5]), .serial_tx_port2_oe(poe[5]),
    .terminal_ready_n_port3(p3[0]), .request_send_n_port3(p3[1]),
    .serial_tx_port3(p3[2]), .carrier_detect_n_port1(dcd_n[0]),
    .ring_indicate_n_port1(ri_n[0]), .clear_to_send_n_port1(cts_n[0]),
    .set_ready_n_port1(dsr_n[0]), .serial_rx_port1(rx[0]),
    .carrier_detect_n_port2(dcd_n[1]), .ring_indicate_n_port2(ri_n[1]),
    .clear_to_send_n_port2(cts_n[1]), .set_ready_n_port2(dsr_n[1]),
    .serial_rx_port2(rx[1]), .carrier_detect_n_port3(dcd_n[2]),
    .ring_indicate_n_port3(ri_n[2]), .clear_to_send_n_port3(cts_n[2]),
    .set_ready_n_port3(dsr_n[2]), .serial_rx_port3(rx[2]),
    .fan_duty_pct(duty), .fan_pwm_mode(pwm), .i2c_slave_addr(i2c),
    .config_index_port(cfg), .firmware_hub_enable(hub_en),
    .strap_done(done));
  slmp_modem i_modem (.line_state, .dcd_n, .ri_n, .cts_n, .dsr_n, .rx);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    if (fail_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus cycle; the request stands until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (!waitrequest) break;
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n == 20) begin
      fail_count++;
      test_done();
    end
  endtask
  // Reset with board pull-downs; checked at 1 ns past the edge, settled.
  task automatic boot(input logic [5:0] lo);
    int n;
    reset <= 1'b1;
    pull_lo <= lo;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (n = 0; n < 40 && !done; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 40) begin
      fail_count++;
      test_done();
    end
    chk(poe, 6'h00);
    @(posedge clk);
    #1;
    chk(poe, 6'h3F);
  endtask
  initial begin
    logic [5:0] lo;
    logic [31:0] sx;
    for (int k = 0; k < 3; k++) begin
      lo = (k == 0) ? 6'h00 : (k == 1) ? 6'h15 : 6'h2A;
      boot(lo);
      sx = {5'h00, 1'b1, !lo[3], !lo[4], lo[2] ? 8'h2E : 8'h4E,
            lo[1] ? 8'h5A : 8'h5C, lo[0] ? 8'h64 : 8'h3C};
      chk({hub_en, pwm, cfg, i2c, duty}, sx[25:0]);
      bus(1'b0, OFS_CTRL, 32'h0);
      chk(q, 32'h124);
      chk({p3, pin}, 9'h1FF);
      foreach (vals[i]) begin
        bus(1'b1, OFS_CTRL, {23'h0, vals[i]});
        bus(1'b0, OFS_CTRL, 32'h0);
        chk(q, {23'h0, vals[i]});
        chk({p3, pin}, vals[i] ^ 9'h0DB);
      end
      // An unmapped write must leave the control word alone.
      bus(1'b1, 4'hC, 32'hFFFFFFFF);
      bus(1'b0, 4'hC, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, OFS_CTRL, 32'h0);
      chk(q, 32'h0A5);
      bus(1'b0, OFS_STRAP, 32'h0);
      chk(q, sx);
      for (int i = 0; i < 16; i++) begin
        line_state <= (i < 15) ? 15'h1 << i : 15'h7FFF;
        repeat (3) @(posedge clk);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q, {17'h0, line_state});
      end
    end
    test_done();
  end
endmodule
`default_nettype wire
